// [rtl/ofs_defines.svh]
`ifndef OFS_DEFINES_SVH
`define OFS_DEFINES_SVH

// ----------------------------------------------------------------
// assignment codes
// ----------------------------------------------------------------
`define OFS_CODE_UNUSED       8'h00
`define OFS_CODE_ECHO_LAST    8'h7F
`define OFS_CODE_CONST_OFF    8'h80
`define OFS_CODE_REV_PULSE    8'h9B
`define OFS_CODE_WRAP_HOME    8'h9C
`define OFS_CODE_STEP_ANGLE   8'h9D
`define OFS_CODE_ZONE_FIRST   8'hA0
`define OFS_CODE_MAIN_POWER   8'hA8
`define OFS_CODE_BRAKE_REL    8'hA9
`define OFS_CODE_USER_A       8'hB4
`define OFS_CODE_USER_B       8'hB5
`define OFS_CODE_CUR_LIMIT    8'hC0
`define OFS_CODE_SPD_LIMIT    8'hC1
`define OFS_CODE_SELF_MOTION  8'hC4
`define OFS_CODE_CMD_READY    8'hCC
`define OFS_CODE_CMD_BUF      8'hCD
`define OFS_CODE_NOTICE_FIRST 8'hE0

// ----------------------------------------------------------------
// field sizes, masks and reset values
// ----------------------------------------------------------------
`define OFS_CODE_W            8
`define OFS_CODE_COUNT        256
`define OFS_ZONE_COUNT        8
`define OFS_NOTICE_COUNT      32
// notice codes that carry a cause; the gaps read as inactive
`define OFS_NOTICE_MASK       32'hF03F6F7F
`define OFS_TERM_RST          1'b0

`endif

// [rtl/ofs_pkg.sv]
package ofs_pkg;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [7:0] ofs_code_t;

    typedef enum logic
    {
        OFS_OP_AND,
        OFS_OP_OR
    } ofs_logic_op_t;

endpackage

// [rtl/ofs_output_selector.sv]
// What this block does
// - code 155 passes the one-revolution pulse of the actual position.
// - code 156 shows wrap home position, only while wrap setting is enabled.
// - code 157 passes the 7.2 degree pulse taken from command position.
// - codes 160 to 167 show whether the motor is inside zone 0 to 7.
// - code 168 reads 1 while main power is on.
// - code 169 reads 1 while the brake is released.
// - codes 180 and 181 output AND or OR of two selectable outputs.
// - code 192 reads 1 while current limiting acts.
// - code 193 reads 1 while speed limiting acts.
// - code 196 shows internal oscillation, forced low in cyclic sync position mode.
// - code 204 reads 1 while the command path is ready.
// - code 205 reads 1 while the command buffer holds data.
// - each listed code 224 to 255 shows its own information cause.
// - code 0 unused, 128 constant off, 1 to 127 echo input states.
`timescale 1ns/100ps
`include "ofs_defines.svh"

module ofs_output_selector
    import ofs_pkg::*;
#(
    parameter int N_TERM = 4
)
(
    // clock and reset
    input  wire logic                               i_core_clk,
    input  wire logic                               i_arst_n,

    // per-terminal assignment codes, terminal k in bits [8k+7:8k]
    input  wire logic [N_TERM*`OFS_CODE_W-1:0]      i_term_code,

    // input signal states for echo codes, bit n for code n
    input  wire logic [127:0]                       i_input_state,

    // motion status
    input  wire logic                               i_rev_pulse,
    input  wire logic                               i_wrap_home_flag,
    input  wire logic                               i_wrap_enable,
    input  wire logic                               i_step_angle_pulse,
    input  wire logic [`OFS_ZONE_COUNT-1:0]         i_zone_flag,
    input  wire logic                               i_self_motion_active,
    input  wire logic                               i_cyclic_sync_position_mode,

    // power, brake and limiting status
    input  wire logic                               i_main_power_on,
    input  wire logic                               i_brake_released,
    input  wire logic                               i_current_limited,
    input  wire logic                               i_speed_limited,

    // command path status
    input  wire logic                               i_command_path_ready,
    input  wire logic                               i_command_buffer_occupied,

    // information causes, bit n for code 224+n
    input  wire logic [`OFS_NOTICE_COUNT-1:0]       i_notice,

    // user logic output a configuration
    input  wire ofs_code_t                          i_user_a_src0,
    input  wire ofs_code_t                          i_user_a_src1,
    input  wire ofs_logic_op_t                      i_user_a_op,

    // user logic output b configuration
    input  wire ofs_code_t                          i_user_b_src0,
    input  wire ofs_code_t                          i_user_b_src1,
    input  wire ofs_logic_op_t                      i_user_b_op,

    // terminals and user logic results
    output logic [N_TERM-1:0]                       o_term,
    output logic                                    o_user_logic_out_a,
    output logic                                    o_user_logic_out_b
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam logic [`OFS_NOTICE_COUNT-1:0] NOTICE_LISTED = `OFS_NOTICE_MASK;

    logic [`OFS_CODE_COUNT-1:0]   base_vec;
    logic [`OFS_CODE_COUNT-1:0]   full_vec;
    logic [`OFS_ZONE_COUNT-1:0]   zone_vec;
    logic [`OFS_NOTICE_COUNT-1:0] notice_vec;
    logic                         wrap_home_gated;
    logic                         self_motion_gated;
    logic                         user_a_s0;
    logic                         user_a_s1;
    logic                         user_b_s0;
    logic                         user_b_s1;
    logic                         user_a_nxt;
    logic                         user_b_nxt;
    logic [N_TERM-1:0]            term_nxt;

    // ----------------------------------------------------------------
    // gated status
    // ----------------------------------------------------------------
    // wrap home means nothing while the wrap setting is off
    assign wrap_home_gated = i_wrap_home_flag & i_wrap_enable;

    // no self motion report in cyclic sync position mode
    assign self_motion_gated = i_self_motion_active
                             & ~i_cyclic_sync_position_mode;

    // ----------------------------------------------------------------
    // zone and notice bits
    // ----------------------------------------------------------------
    genvar z;
    generate
        for (z = 0; z < `OFS_ZONE_COUNT; z++)
        begin : g_zone
            assign zone_vec[z] = i_zone_flag[z];
        end
    endgenerate

    // unlisted notice codes read as constant off
    genvar n;
    generate
        for (n = 0; n < `OFS_NOTICE_COUNT; n++)
        begin : g_notice
            assign notice_vec[n] = i_notice[n] & NOTICE_LISTED[n];
        end
    endgenerate

    // ----------------------------------------------------------------
    // status vector indexed by assignment code
    // ----------------------------------------------------------------
    // user entries stay 0 here so a user output cannot feed on itself
    always_comb
    begin
        base_vec = '0;
        base_vec[127:0] = i_input_state;
        base_vec[`OFS_CODE_UNUSED] = 1'b0;
        base_vec[`OFS_CODE_CONST_OFF] = 1'b0;
        base_vec[`OFS_CODE_REV_PULSE] = i_rev_pulse;
        base_vec[`OFS_CODE_WRAP_HOME] = wrap_home_gated;
        base_vec[`OFS_CODE_STEP_ANGLE] = i_step_angle_pulse;
        base_vec[`OFS_CODE_ZONE_FIRST +: `OFS_ZONE_COUNT] = zone_vec;
        base_vec[`OFS_CODE_MAIN_POWER] = i_main_power_on;
        base_vec[`OFS_CODE_BRAKE_REL] = i_brake_released;
        base_vec[`OFS_CODE_CUR_LIMIT] = i_current_limited;
        base_vec[`OFS_CODE_SPD_LIMIT] = i_speed_limited;
        base_vec[`OFS_CODE_SELF_MOTION] = self_motion_gated;
        base_vec[`OFS_CODE_CMD_READY] = i_command_path_ready;
        base_vec[`OFS_CODE_CMD_BUF] = i_command_buffer_occupied;
        base_vec[`OFS_CODE_NOTICE_FIRST +: `OFS_NOTICE_COUNT] = notice_vec;
    end

    // ----------------------------------------------------------------
    // user logic output a
    // ----------------------------------------------------------------
    assign user_a_s0 = base_vec[i_user_a_src0];
    assign user_a_s1 = base_vec[i_user_a_src1];

    always_comb
    begin
        case (i_user_a_op)
            OFS_OP_AND: user_a_nxt = user_a_s0 & user_a_s1;
            OFS_OP_OR:  user_a_nxt = user_a_s0 | user_a_s1;
            default:    user_a_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_user_logic_out_a <= `OFS_TERM_RST;
        else
            o_user_logic_out_a <= user_a_nxt;
    end

    // ----------------------------------------------------------------
    // user logic output b
    // ----------------------------------------------------------------
    assign user_b_s0 = base_vec[i_user_b_src0];
    assign user_b_s1 = base_vec[i_user_b_src1];

    always_comb
    begin
        case (i_user_b_op)
            OFS_OP_AND: user_b_nxt = user_b_s0 & user_b_s1;
            OFS_OP_OR:  user_b_nxt = user_b_s0 | user_b_s1;
            default:    user_b_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_user_logic_out_b <= `OFS_TERM_RST;
        else
            o_user_logic_out_b <= user_b_nxt;
    end

    // ----------------------------------------------------------------
    // full vector with user results
    // ----------------------------------------------------------------
    always_comb
    begin
        full_vec = base_vec;
        full_vec[`OFS_CODE_USER_A] = user_a_nxt;
        full_vec[`OFS_CODE_USER_B] = user_b_nxt;
    end

    // ----------------------------------------------------------------
    // terminal selection
    // ----------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < N_TERM; k++)
        begin : g_term
            ofs_code_t term_code;

            assign term_code = i_term_code[k*`OFS_CODE_W +: `OFS_CODE_W];
            assign term_nxt[k] = full_vec[term_code];
        end
    endgenerate

    // ----------------------------------------------------------------
    // terminal registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_term <= {N_TERM{`OFS_TERM_RST}};
        else
            o_term <= term_nxt;
    end

endmodule

// [verification/ofs_host_inputs.sv]
`timescale 1ns/100ps
module ofs_host_inputs
(
    // clock, reset and terminals
    input  wire logic       i_core_clk,
    input  wire logic       i_arst_n,
    input  wire logic [3:0] i_term,
    // levels as the host last sampled them
    output logic [3:0]      o_seen
);
    always_ff @(posedge i_core_clk or negedge i_arst_n)
        if (!i_arst_n)
            o_seen <= '0;
        else
            o_seen <= i_term;
endmodule

// [verification/ofs_output_selector_sva.sv]
`timescale 1ns/100ps
module ofs_output_selector_chk
    import ofs_pkg::*;
#(
    parameter int N_TERM = 4
)
(
    input wire logic                i_core_clk, i_arst_n, i_rev_pulse, i_wrap_home_flag,
    input wire logic                i_wrap_enable, i_self_motion_active, i_main_power_on,
    input wire logic                i_cyclic_sync_position_mode, i_brake_released,
    input wire logic                i_current_limited,
    input wire logic [N_TERM*8-1:0] i_term_code,
    input wire logic [7:0]          i_zone_flag,
    input wire logic [N_TERM-1:0]   o_term
);
    logic [7:0] c0;
    logic       zone_hit;
    assign c0 = i_term_code[7:0];
    assign zone_hit = i_zone_flag[c0[2:0]];
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    power_follow_a: assert property
        (c0 == 8'hA8 |=> o_term[0] == $past(i_main_power_on))
        else $error("power code mismatch");
    brake_follow_a: assert property
        (c0 == 8'hA9 |=> o_term[0] == $past(i_brake_released))
        else $error("brake code mismatch");
    wrap_gate_a: assert property
        (c0 == 8'h9C && i_wrap_enable |=> o_term[0] == $past(i_wrap_home_flag))
        else $error("wrap home mismatch");
    wrap_block_a: assert property
        (c0 == 8'h9C && !i_wrap_enable |=> !o_term[0])
        else $error("wrap home not blocked");
    csp_block_a: assert property
        (c0 == 8'hC4 && i_cyclic_sync_position_mode |=> !o_term[0])
        else $error("self motion not blocked");
    zone_select_a: assert property
        (c0[7:3] == 5'h14 |=> o_term[0] == $past(zone_hit))
        else $error("zone mismatch");
    const_off_a: assert property
        ((c0 == 8'h00 || c0 == 8'h80) |=> !o_term[0])
        else $error("inactive code drives high");
    rev_pulse_a: assert property
        (c0 == 8'h9B |=> o_term[0] == $past(i_rev_pulse))
        else $error("revolution pulse mismatch");
    cur_limit_a: assert property
        (c0 == 8'hC0 |-> ##1 o_term[0] == $past(i_current_limited))
        else $error("current limit mismatch");
    cover property (c0 == 8'hB4 ##1 o_term[0]);
    cover property (c0[7:3] == 5'h14 ##1 o_term[0]);
    cover property (c0 == 8'hC4 && i_cyclic_sync_position_mode);
endmodule

bind ofs_output_selector ofs_output_selector_chk #(.N_TERM(N_TERM)) ofs_output_selector_chk_inst
(
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_rev_pulse(i_rev_pulse),
    .i_wrap_home_flag(i_wrap_home_flag), .i_wrap_enable(i_wrap_enable),
    .i_self_motion_active(i_self_motion_active), .i_main_power_on(i_main_power_on),
    .i_cyclic_sync_position_mode(i_cyclic_sync_position_mode),
    .i_brake_released(i_brake_released), .i_current_limited(i_current_limited),
    .i_term_code(i_term_code), .i_zone_flag(i_zone_flag), .o_term(o_term)
);

// [verification/ofs_output_selector_bench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) \
    begin failures++; $display("Error %0t: bad %b", $time, (a)); end end
module ofs_output_selector_bench import ofs_pkg::*;;
    logic          clk = 0;
    logic          rst_n = 0;
    logic [31:0]   code = '0;
    logic [127:0]  ins = '0;
    logic          rev = 0, home = 0, wen = 0, step = 0, self_m = 0, cyclic_sync_position_mode = 0;
    logic [7:0]    zone = '0;
    logic [5:0]    st = '0;
    logic [31:0]   note = '0;
    ofs_code_t     a0 = 8'hA8, a1 = 8'hA9, b0 = 8'hA8, b1 = 8'hA9;
    ofs_logic_op_t aop = OFS_OP_AND, bop = OFS_OP_OR;
    wire [3:0]     term;
    wire           ua, ub;
    wire [3:0]     seen;
    int            failures = 0, checked = 0;
    ofs_code_t     lc [6] = '{8'hA8, 8'hA9, 8'hC0, 8'hC1, 8'hCC, 8'hCD};
    ofs_code_t     unl [4] = '{8'h9E, 8'hB0, 8'hC2, 8'hDF};
    always #25 clk = ~clk;
    ofs_output_selector ofs_output_selector_inst
    (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_term_code(code), .i_input_state(ins),
        .i_rev_pulse(rev), .i_wrap_home_flag(home), .i_wrap_enable(wen),
        .i_step_angle_pulse(step), .i_zone_flag(zone), .i_self_motion_active(self_m),
        .i_cyclic_sync_position_mode(cyclic_sync_position_mode), .i_main_power_on(st[0]), .i_brake_released(st[1]),
        .i_current_limited(st[2]), .i_speed_limited(st[3]), .i_command_path_ready(st[4]),
        .i_command_buffer_occupied(st[5]), .i_notice(note), .i_user_a_src0(a0),
        .i_user_a_src1(a1), .i_user_a_op(aop), .i_user_b_src0(b0), .i_user_b_src1(b1),
        .i_user_b_op(bop), .o_term(term), .o_user_logic_out_a(ua), .o_user_logic_out_b(ub)
    );
    ofs_host_inputs ofs_host_inputs_inst
    (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_term(term), .o_seen(seen)
    );
    // all terminals get one code, result seen one edge later
    task run(input ofs_code_t c, input logic e);
        begin
            code = {4{c}};
            @(negedge clk);
            `CHK(term, {4{e}})
        end
    endtask
    task wrap_up;
        begin
            $display("checked %0d failures %0d", checked, failures);
            if (failures == 0 && checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        `CHK(term, 4'h0)
        rst_n = 1;
        for (int i = 0; i < 36; i++)
        begin
            st = 6'h01 << (i / 6);
            run(lc[i % 6], (i / 6) == (i % 6));
        end
        $display("levels done");
        for (int z = 0; z < 8; z++)
        begin
            zone = 8'h01 << z;
            run(8'hA0 + z[7:0], 1'b1);
            run(8'hA0 + 8'((z + 1) % 8), 1'b0);
        end
        for (int n = 0; n < 32; n++)
        begin
            note = 32'h1 << n;
            run(8'hE0 + n[7:0],
                !(n == 7 || n == 12 || n == 15 || (n > 21 && n < 28)));
        end
        $display("zones and notices done");
        home = 1;
        run(8'h9C, 1'b0);
        wen = 1;
        run(8'h9C, 1'b1);
        self_m = 1;
        cyclic_sync_position_mode = 1;
        run(8'hC4, 1'b0);
        cyclic_sync_position_mode = 0;
        run(8'hC4, 1'b1);
        rev = 1;
        step = 1;
        run(8'h9B, 1'b1);
        rev = 0;
        run(8'h9B, 1'b0);
        run(8'h9D, 1'b1);
        step = 0;
        run(8'h9D, 1'b0);
        ins = 128'h20;
        run(8'h05, 1'b1);
        run(8'h06, 1'b0);
        {ins, st, zone, note} = '1;
        run(8'h00, 1'b0);
        run(8'h80, 1'b0);
        run(8'h7F, 1'b1);
        for (int k = 0; k < 4; k++)
            run(unl[k], 1'b0);
        st = 6'h01;
        run(8'hB4, 1'b0);
        `CHK(ua, 1'b0)
        run(8'hB5, 1'b1);
        `CHK(ub, 1'b1)
        aop = OFS_OP_OR;
        run(8'hB4, 1'b1);
        @(negedge clk);
        `CHK(seen, term)
        $display("misc done");
        wrap_up();
    end
endmodule
